// ===== tvt_timing.sv
// Television timing top: AHB-Lite registers and field sequencer
//
// Chosen here: the AHB-Lite slave port and the placing of the registers.
`include "tvt_defines.svh"
`default_nettype none
module tvt_timing (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output logic             tv_hsync,
    output logic             tv_vsync,
    output logic             tv_blank,
    output logic [1:0]       tv_field
);
    tvt_hline_if hl ();

    // Register state
    logic [6:0]  hdisp_ff,   nxt_hdisp;
    logic [5:0]  hndisp_ff,  nxt_hndisp;
    logic [5:0]  hsstart_ff, nxt_hsstart;
    logic [9:0]  vdisp_ff,   nxt_vdisp;
    logic [6:0]  vndisp_ff,  nxt_vndisp;
    logic [6:0]  vsstart_ff, nxt_vsstart;
    logic [2:0]  ctrl_ff,    nxt_ctrl;
    logic [31:0] rdata_ff,   nxt_rdata;
    logic        wr_ff,      nxt_wr;
    logic [7:0]  widx_ff,    nxt_widx;
    logic [7:0]  aidx;
    logic        acc;
    // Divider and frame state
    logic [3:0]  div_ff,     nxt_div;
    logic [9:0]  vhl_ff,     nxt_vhl;
    logic [1:0]  field_ff,   nxt_field;
    logic        vsync_ff,   nxt_vsync;
    logic        vblank_ff,  nxt_vblank;
    logic [9:0]  fld_halves;
    logic [9:0]  blk_halves;
    logic [9:0]  vs_on;
    logic [8:0]  vs_off9;
    logic        pal;
    logic        odd_fld;

    // Address phase decode; any transfer type above BUSY is real
    always_comb begin
        acc  = hsel && hready && htrans[1];
        aidx = haddr[9:2];
    end

    // Register writes land in the data phase; reads sample next values
    always_comb begin
        nxt_hdisp   = hdisp_ff;
        nxt_hndisp  = hndisp_ff;
        nxt_hsstart = hsstart_ff;
        nxt_vdisp   = vdisp_ff;
        nxt_vndisp  = vndisp_ff;
        nxt_vsstart = vsstart_ff;
        nxt_ctrl    = ctrl_ff;
        if (wr_ff) begin
            unique case (widx_ff)
                `TVT_IDX_HDISP:    nxt_hdisp   = hwdata[6:0];
                `TVT_IDX_HNDISP:   nxt_hndisp  = hwdata[5:0];
                `TVT_IDX_HSSTART:  nxt_hsstart = hwdata[5:0];
                `TVT_IDX_VDISP_LO: nxt_vdisp   = {vdisp_ff[9:8], hwdata[7:0]};
                `TVT_IDX_VDISP_HI: nxt_vdisp   = {hwdata[1:0], vdisp_ff[7:0]};
                `TVT_IDX_VNDISP:   nxt_vndisp  = hwdata[6:0];
                `TVT_IDX_VSSTART:  nxt_vsstart = hwdata[6:0];
                `TVT_IDX_CTRL:     nxt_ctrl    = hwdata[2:0];
                default:           nxt_ctrl    = ctrl_ff;
            endcase
        end
        nxt_wr    = acc && hwrite;
        nxt_widx  = acc ? aidx : widx_ff;
        nxt_rdata = rdata_ff;
        // Read data taken from next values so a write just before is seen
        if (acc && !hwrite) begin
            unique case (aidx)
                `TVT_IDX_HDISP:    nxt_rdata = {25'h0, nxt_hdisp};
                `TVT_IDX_HNDISP:   nxt_rdata = {26'h0, nxt_hndisp};
                `TVT_IDX_HSSTART:  nxt_rdata = {26'h0, nxt_hsstart};
                `TVT_IDX_VDISP_LO: nxt_rdata = {24'h0, nxt_vdisp[7:0]};
                `TVT_IDX_VDISP_HI: nxt_rdata = {30'h0, nxt_vdisp[9:8]};
                `TVT_IDX_VNDISP:   nxt_rdata = {25'h0, nxt_vndisp};
                `TVT_IDX_VSSTART:  nxt_rdata = {25'h0, nxt_vsstart};
                `TVT_IDX_CTRL:     nxt_rdata = {29'h0, nxt_ctrl};
                `TVT_IDX_STATUS:   nxt_rdata = {16'h0, vblank_ff, vsync_ff,
                                                field_ff, 2'h0, vhl_ff};
                default:           nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hdisp_ff   <= `TVT_RST_HDISP;
            hndisp_ff  <= `TVT_RST_HNDISP;
            hsstart_ff <= `TVT_RST_HSSTART;
            vdisp_ff   <= `TVT_RST_VDISP;
            vndisp_ff  <= `TVT_RST_VNDISP;
            vsstart_ff <= `TVT_RST_VSSTART;
            ctrl_ff    <= `TVT_RST_CTRL;
            rdata_ff   <= 32'h0000_0000;
            wr_ff      <= 1'b0;
            widx_ff    <= 8'h00;
        end else begin
            hdisp_ff   <= nxt_hdisp;
            hndisp_ff  <= nxt_hndisp;
            hsstart_ff <= nxt_hsstart;
            vdisp_ff   <= nxt_vdisp;
            vndisp_ff  <= nxt_vndisp;
            vsstart_ff <= nxt_vsstart;
            ctrl_ff    <= nxt_ctrl;
            rdata_ff   <= nxt_rdata;
            wr_ff      <= nxt_wr;
            widx_ff    <= nxt_widx;
        end
    end

    // Zero-wait slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_ff;

    // Line timer wiring; registers change timing on the fly, no shadowing
    assign hl.run     = ctrl_ff[`TVT_CTRL_RUN];
    assign hl.std     = ctrl_ff[`TVT_CTRL_PAL] ? tvt_pkg::TVT_STD_PAL
                                               : tvt_pkg::TVT_STD_NTSC;
    assign hl.bpp16   = ctrl_ff[`TVT_CTRL_BPP16];
    assign hl.hdisp   = hdisp_ff;
    assign hl.hndisp  = hndisp_ff;
    assign hl.hsstart = hsstart_ff;
    assign hl.tick    = (div_ff == 4'(`TVT_SC_DIV - 1));

    tvt_hline u_hline (
        .mclk  (mclk),
        .rst_n (rst_n),
        .hl    (hl.line)
    );

    // Field geometry in half lines; blanking opens each field
    always_comb begin
        pal        = ctrl_ff[`TVT_CTRL_PAL];
        odd_fld    = !field_ff[0];              // fields one and three
        blk_halves = {2'h0, vndisp_ff, 1'b0}
                   + (odd_fld ? 10'h002 : 10'h004);
        // Half of (height + 1) lines is (height + 1) half lines
        fld_halves = vdisp_ff + 10'h001 + blk_halves;
        if (pal) begin
            vs_off9 = odd_fld ? `TVT_VS_PAL_ODD : `TVT_VS_HALF;
        end else begin
            vs_off9 = (field_ff == 2'h0) ? `TVT_VS_NTSC_F1
                                          : `TVT_VS_HALF;
        end
        vs_on = {2'h0, vsstart_ff, 1'b0} + {1'b0, vs_off9};
    end

    // Divider, half-line counter and field order
    always_comb begin
        nxt_div    = hl.tick ? 4'h0 : div_ff + 4'h1;
        nxt_vhl    = vhl_ff;
        nxt_field  = field_ff;
        nxt_vsync  = vsync_ff;
        nxt_vblank = vblank_ff;
        if (!hl.run) begin
            nxt_vhl    = 10'h000;
            nxt_field  = 2'h0;
            nxt_vsync  = 1'b0;
            nxt_vblank = 1'b1;
        end else if (hl.line_end || hl.half_line) begin
            if (vhl_ff >= fld_halves - 10'h001) begin
                nxt_vhl = 10'h000;
                // Fixed cycle: NTSC 0,1 and PAL 0,1,2,3
                if (field_ff == (pal ? `TVT_PAL_LAST_FLD
                                     : `TVT_NTSC_LAST_FLD)) begin
                    nxt_field = 2'h0;
                end else begin
                    nxt_field = field_ff + 2'h1;
                end
            end else begin
                nxt_vhl = vhl_ff + 10'h001;
            end
            nxt_vblank = nxt_vhl < blk_halves;
            nxt_vsync  = (nxt_vhl >= vs_on)
                      && (nxt_vhl < vs_on + {1'b0, `TVT_VSYNC_HALVES});
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            div_ff    <= 4'h0;
            vhl_ff    <= 10'h000;
            field_ff  <= 2'h0;
            vsync_ff  <= 1'b0;
            vblank_ff <= 1'b1;
        end else begin
            div_ff    <= nxt_div;
            vhl_ff    <= nxt_vhl;
            field_ff  <= nxt_field;
            vsync_ff  <= nxt_vsync;
            vblank_ff <= nxt_vblank;
        end
    end

    // Pin outputs from flops; blank is the OR of the vertical and horizontal blank flops
    assign tv_hsync = hl.hsync;
    assign tv_vsync = vsync_ff;
    assign tv_blank = vblank_ff || hl.hblank;
    assign tv_field = field_ff;
endmodule // tvt_timing
`default_nettype wire

// ===== tvt_defines.svh
// Constants for the composite television timing block
`ifndef TVT_DEFINES_SVH
`define TVT_DEFINES_SVH
// Register indices; byte address is four times the index
`define TVT_IDX_HDISP     8'h50
`define TVT_IDX_HNDISP    8'h52
`define TVT_IDX_HSSTART   8'h53
`define TVT_IDX_VDISP_LO  8'h56
`define TVT_IDX_VDISP_HI  8'h57
`define TVT_IDX_VNDISP    8'h58
`define TVT_IDX_VSSTART   8'h59
`define TVT_IDX_CTRL      8'h5B
`define TVT_IDX_STATUS    8'h5C
// Reset values: a legal NTSC frame
`define TVT_RST_HDISP     7'h4F
`define TVT_RST_HNDISP    6'h21
`define TVT_RST_HSSTART   6'h02
`define TVT_RST_VDISP     10'h1E3
`define TVT_RST_VNDISP    7'h13
`define TVT_RST_VSSTART   7'h00
`define TVT_RST_CTRL      3'h1
// Control bit positions
`define TVT_CTRL_RUN      0
`define TVT_CTRL_PAL      1
`define TVT_CTRL_BPP16    2
// Subcarrier period in ps and the mclk period in ps
`define TVT_T4SC_NTSC_PS  69841
`define TVT_T4SC_PAL_PS   56387
`define TVT_MCLK_PS       100000
// Cycles of mclk per subcarrier period, rounded up, at least one
`define TVT_SC_DIV ((`TVT_T4SC_NTSC_PS + `TVT_MCLK_PS - 1) / `TVT_MCLK_PS)
// Horizontal figures in subcarrier periods
`define TVT_HSYNC_NTSC    11'h043
`define TVT_HSYNC_PAL     11'h053
`define TVT_HBLANK_NTSC   11'h006
`define TVT_HBLANK_PAL    11'h007
`define TVT_FP_SUB_8BPP   11'h007
`define TVT_FP_SUB_16BPP  11'h005
// Vertical sync offsets and width in half lines, last field index of each standard
`define TVT_VS_NTSC_F1    9'h008
`define TVT_VS_PAL_ODD    9'h00A
`define TVT_VS_HALF       9'h009
`define TVT_VSYNC_HALVES  9'h006
`define TVT_NTSC_LAST_FLD 2'h1
`define TVT_PAL_LAST_FLD  2'h3
`endif

// ===== tvt_pkg.sv
// Types shared by the television timing modules
`default_nettype none
package tvt_pkg;
    typedef enum logic {
        TVT_STD_NTSC = 1'b0,
        TVT_STD_PAL  = 1'b1
    } tvt_std_type;
endpackage
`default_nettype wire

// ===== tvt_hline_if.sv
// Link between the frame sequencer and the line timer
`default_nettype none
interface tvt_hline_if;
    logic                 tick;
    logic                 run;
    tvt_pkg::tvt_std_type std;
    logic                 bpp16;
    logic [6:0]           hdisp;
    logic [5:0]           hndisp;
    logic [5:0]           hsstart;
    logic                 hsync;
    logic                 hblank;
    logic                 line_end;
    logic                 half_line;
    modport ctrl (output tick, run, std, bpp16, hdisp, hndisp, hsstart,
                  input hsync, hblank, line_end, half_line);
    modport line (input tick, run, std, bpp16, hdisp, hndisp, hsstart,
                  output hsync, hblank, line_end, half_line);
endinterface
`default_nettype wire

// ===== tvt_hline.sv
// Horizontal line timer in subcarrier periods
`include "tvt_defines.svh"
`default_nettype none
module tvt_hline (
    input  wire logic mclk,
    input  wire logic rst_n,
    tvt_hline_if.line hl
);
    logic [10:0] hcnt_ff;
    logic [10:0] nxt_hcnt;
    logic        hsync_ff;
    logic        nxt_hsync;
    logic        hblank_ff;
    logic        nxt_hblank;
    logic [10:0] act_len;
    logic [10:0] line_len;
    logic [10:0] sync_on;
    logic [10:0] sync_off;
    logic        pal;

    // Interval lengths from the programmed fields
    always_comb begin
        pal      = (hl.std == tvt_pkg::TVT_STD_PAL);
        act_len  = {1'b0, hl.hdisp, 3'h0} + 11'h008;
        line_len = act_len + {2'h0, hl.hndisp, 3'h0}
                 + (pal ? `TVT_HBLANK_PAL : `TVT_HBLANK_NTSC);
        // Front porch follows active video, then the sync tip
        sync_on  = act_len + {2'h0, hl.hsstart, 3'h0} + 11'h008
                 - (hl.bpp16 ? `TVT_FP_SUB_16BPP : `TVT_FP_SUB_8BPP);
        sync_off = sync_on
                 + (pal ? `TVT_HSYNC_PAL : `TVT_HSYNC_NTSC);
    end

    // Counter advances once per subcarrier tick
    always_comb begin
        nxt_hcnt   = hcnt_ff;
        nxt_hsync  = hsync_ff;
        nxt_hblank = hblank_ff;
        if (!hl.run) begin
            nxt_hcnt   = 11'h000;
            nxt_hsync  = 1'b0;
            nxt_hblank = 1'b1;
        end else if (hl.tick) begin
            nxt_hcnt   = hl.line_end ? 11'h000 : hcnt_ff + 11'h001;
            nxt_hblank = nxt_hcnt >= act_len;
            nxt_hsync  = (nxt_hcnt >= sync_on) && (nxt_hcnt < sync_off);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hcnt_ff   <= 11'h000;
            hsync_ff  <= 1'b0;
            hblank_ff <= 1'b1;
        end else begin
            hcnt_ff   <= nxt_hcnt;
            hsync_ff  <= nxt_hsync;
            hblank_ff <= nxt_hblank;
        end
    end

    // Strobes are combinational so the sequencer sees them in step
    assign hl.line_end  = hl.run && hl.tick && (hcnt_ff == line_len - 11'h001);
    assign hl.half_line = hl.run && hl.tick
                       && (hcnt_ff == {1'b0, line_len[10:1]} - 11'h001);
    assign hl.hsync  = hsync_ff;
    assign hl.hblank = hblank_ff;
endmodule // tvt_hline
`default_nettype wire

// ===== tvt_tv_rx.sv
// Receiver model: measures sync, blanking and field timing in mclk ticks
`default_nettype none
module tvt_tv_rx (
    input  wire logic        mclk,
    input  wire logic        hs,
    input  wire logic        vs,
    input  wire logic        bl,
    input  wire logic [1:0]  fld,
    output logic      [19:0] m [5],
    output logic      [19:0] fm [3][4]
);
    logic [19:0] now = 20'h0;
    logic [19:0] nl  = 20'h0;
    logic [19:0] t_hs, t_bl, t_act, t_fld, t_vs;
    logic        hs_q, vs_q, bl_q;
    logic [1:0]  fd_q;

    // One tick is one subcarrier period, so widths come out directly
    always @(posedge mclk) begin
        now <= now + 20'h1;
        {hs_q, vs_q, bl_q, fd_q} <= {hs, vs, bl, fld};
        if (hs && !hs_q) begin
            m[1] <= now - t_hs;
            t_hs <= now;
            // Porch only counts when active video ended in this line
            if (t_bl > t_hs) m[3] <= now - t_bl;
        end
        if (!hs && hs_q) m[0] <= now - t_hs;
        if (bl && !bl_q) begin
            m[2] <= now - t_act;
            t_bl <= now;
        end
        if (!bl && bl_q) begin
            t_act <= now;
            nl <= nl + 20'h1;
            if (nl == 20'h0) fm[1][fld] <= now - t_fld;
        end
        if (vs && !vs_q) begin
            t_vs <= now;
            fm[0][fld] <= now - t_fld;
        end
        if (!vs && vs_q) m[4] <= now - t_vs;
        // Field change closes the display line count of the old field
        if (fld != fd_q) begin
            t_fld <= now;
            fm[2][fd_q] <= nl;
            nl <= 20'h0;
        end
    end
endmodule // tvt_tv_rx
`default_nettype wire

// ===== tvt_timing_props.sv
// Assertions on the television timing block's bus and video ports
`default_nettype none
module tvt_timing_props (
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        tv_hsync,
    input wire logic        tv_vsync,
    input wire logic        tv_blank,
    input wire logic [1:0]  tv_field
);
    logic        ap_v_ff, ap_w_ff, hs_q_ff, run_ff, pal_ff;
    logic [7:0]  ap_i_ff;
    logic [11:0] hs_cnt_ff, ln_cnt_ff, vs_cnt_ff;

    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    // Shadow of run and standard; counters cleared while stopped
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            {ap_v_ff, ap_w_ff, hs_q_ff, pal_ff} <= 4'h0;
            run_ff <= 1'b1;
            ap_i_ff <= 8'h00;
            {hs_cnt_ff, ln_cnt_ff, vs_cnt_ff} <= 36'h0;
        end else begin
            ap_v_ff <= hsel && hready && htrans[1];
            ap_w_ff <= hwrite;
            ap_i_ff <= haddr[9:2];
            if (ap_v_ff && ap_w_ff && ap_i_ff == 8'h5B) begin
                run_ff <= hwdata[0];
                pal_ff <= hwdata[1];
            end
            hs_q_ff <= tv_hsync;
            hs_cnt_ff <= (tv_hsync && run_ff) ? hs_cnt_ff + 12'h1 : 12'h0;
            vs_cnt_ff <= (tv_vsync && run_ff) ? vs_cnt_ff + 12'h1 : 12'h0;
            if (!run_ff) ln_cnt_ff <= 12'h0;
            else if (tv_hsync && !hs_q_ff) ln_cnt_ff <= 12'h1;
            else if (ln_cnt_ff != 12'h0) ln_cnt_ff <= ln_cnt_ff + 12'h1;
        end
    end

    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not OKAY");
    a_unmapped_zero: assert property (ap_v_ff && !ap_w_ff && !(ap_i_ff
        inside {8'h50, 8'h52, 8'h53, [8'h56:8'h59], 8'h5B, 8'h5C})
        |-> hrdata == 32'h0) else $error("unmapped read not zero");
    a_upper_zero: assert property (ap_v_ff && !ap_w_ff
        |-> hrdata[31:16] == 16'h0) else $error("read upper bits set");
    a_hsync_width: assert property (
        run_ff && $fell(tv_hsync) |-> hs_cnt_ff == (pal_ff ? 12'h053 : 12'h043))
        else $error("hsync width wrong");
    a_line_period: assert property (
        run_ff && $rose(tv_hsync) && ln_cnt_ff != 12'h0
        |-> ln_cnt_ff == (pal_ff ? 12'h46F : 12'h38E))
        else $error("line period wrong");
    a_sync_blanked: assert property (tv_hsync |-> tv_blank)
        else $error("hsync outside blanking");
    a_vsync_width: assert property (
        run_ff && $fell(tv_vsync) |-> vs_cnt_ff == (pal_ff ? 12'hD4D : 12'hAAA))
        else $error("vsync width wrong");
    a_field_order: assert property (
        run_ff && $changed(tv_field) |-> tv_field == (($past(tv_field) ==
        (pal_ff ? 2'h3 : 2'h1)) ? 2'h0 : $past(tv_field) + 2'h1))
        else $error("field order wrong");
    a_stop_idle: assert property (!run_ff [*3] |-> tv_blank && !tv_hsync
        && !tv_vsync && tv_field == 2'h0) else $error("stopped output busy");
endmodule // tvt_timing_props
bind tvt_timing tvt_timing_props u_props (.mclk, .rst_n, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
    .tv_hsync, .tv_vsync, .tv_blank, .tv_field);
`default_nettype wire

// ===== tv_ntsc_pal_timing_tb.sv
// Self-checking bench for the television timing block
`default_nettype none
module tv_ntsc_pal_timing_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    wire logic   hreadyout, hresp, tv_hsync, tv_vsync, tv_blank;
    wire logic [31:0] hrdata;
    wire logic [1:0]  tv_field;
    logic [19:0] m [5], fm [3][4];
    int          err_count = 0, checked = 0;

    tvt_timing uut (.mclk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .tv_hsync,
        .tv_vsync, .tv_blank, .tv_field);
    tvt_tv_rx u_rx (.mclk, .hs(tv_hsync), .vs(tv_vsync), .bl(tv_blank),
        .fld(tv_field), .m, .fm);

    // 10 MHz clock
    initial forever #50 mclk = ~mclk;

    // One single-word transfer, held until hready is seen high
    task automatic bus(input logic w, input logic [7:0] i,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge mclk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 22'h0, i, 2'h0};
        do @(posedge mclk); while (hreadyout !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        do @(posedge mclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    task automatic check(input string n, input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %s expected %0h seen %0h", n, e, s);
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Stop first: registers have no shadow copy
    // Height high bits written too, else an earlier scenario leaks in
    task automatic prog(input logic [31:0] c, hd, hn, hs, vd, vn, vs);
        logic [7:0]  a [9] = '{8'h5B, 8'h50, 8'h52, 8'h53, 8'h56, 8'h57,
                               8'h58, 8'h59, 8'h5B};
        logic [31:0] v [9];
        v = '{32'h0, hd, hn, hs, vd, vd >> 8, vn, vs, c};
        for (int i = 0; i < 9; i++) bus(1'b1, a[i], v[i], rd);
    endtask

    task automatic wait_fld(input logic [1:0] f);
        int n;
        n = 0;
        while (tv_field !== f && n < 20000) begin
            @(posedge mclk);
            n++;
        end
        check("field index", {30'h0, tv_field}, {30'h0, f});
    endtask

    function automatic int hl(input int k, input int l);
        return (k / 2) * l + (k % 2) * (l / 2);
    endfunction

    task automatic chk_line(input int l, w, a, p);
        check("hsync width", m[0], w);
        check("line period", m[1], l);
        check("active width", m[2], a);
        check("front porch", m[3], p);
    endtask

    task automatic chk_fields(input int n, l, vn, a, b);
        for (int i = 0; i < n; i++) begin
            check("vsync offset", fm[0][i], hl(i % 2 ? b : a, l));
            check("blank lines", fm[1][i], (vn + 1 + i % 2) * l);
            check("display lines", fm[2][i], 4);
        end
        check("vsync width", m[4], 3 * l);
    endtask

    task automatic t_regs;
        logic [7:0]  a [9] = '{8'h50, 8'h52, 8'h53, 8'h56, 8'h57, 8'h58,
                               8'h59, 8'h5B, 8'h40};
        logic [31:0] e [9] = '{32'h4F, 32'h21, 32'h2, 32'hE3, 32'h1, 32'h13,
                               32'h0, 32'h1, 32'h0};
        for (int i = 0; i < 9; i++) begin
            bus(1'b0, a[i], 32'h0, rd);
            check("reset value", rd, e[i]);
        end
        $display("t_regs done");
    endtask

    // Field widths, unmapped write, with the timing stopped
    task automatic t_access;
        bus(1'b1, 8'h5B, 32'h0, rd);
        bus(1'b1, 8'h53, 32'hFFFFFFFF, rd);
        bus(1'b0, 8'h53, 32'h0, rd);
        check("sync start field", rd, 32'h3F);
        bus(1'b1, 8'h57, 32'hFFFFFFFF, rd);
        bus(1'b0, 8'h57, 32'h0, rd);
        check("height high field", rd, 32'h3);
        bus(1'b1, 8'h40, 32'hFFFFFFFF, rd);
        bus(1'b0, 8'h40, 32'h0, rd);
        check("unmapped", rd, 32'h0);
        $display("t_access done");
    endtask

    // Short frame keeps the run brief; line stays legal
    task automatic t_ntsc;
        prog(32'h1, 32'h4F, 32'h21, 32'h2, 32'h7, 32'h4, 32'h1);
        wait_fld(2'h1);
        wait_fld(2'h0);
        // Two extra cycles let the receiver close field 0 first
        repeat (9 * 910 + 2) @(posedge mclk);
        chk_line(910, 67, 640, 17);
        chk_fields(2, 910, 4, 10, 11);
        $display("t_ntsc done");
    endtask

    task automatic t_bpp16;
        bus(1'b1, 8'h5B, 32'h0, rd);
        bus(1'b1, 8'h5B, 32'h5, rd);
        repeat (7 * 910) @(posedge mclk);
        chk_line(910, 67, 640, 19);
        $display("t_bpp16 done");
    endtask

    task automatic t_pal;
        prog(32'h3, 32'h63, 32'h29, 32'h5, 32'h7, 32'h4, 32'h0);
        wait_fld(2'h1);
        wait_fld(2'h2);
        wait_fld(2'h3);
        wait_fld(2'h0);
        // Second field 0 must be closed, the first one inherited old counts
        repeat (9 * 1135 + 2) @(posedge mclk);
        chk_line(1135, 83, 800, 41);
        chk_fields(4, 1135, 4, 10, 9);
        $display("t_pal done");
    endtask

    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        t_regs();
        t_access();
        t_ntsc();
        t_bpp16();
        t_pal();
        results();
    end

    // Watchdog: all scenarios need about 86000 cycles
    initial begin
        repeat (99000) @(posedge mclk);
        err_count++;
        results();
    end
endmodule // tv_ntsc_pal_timing_tb
`default_nettype wire
